// ==== dv/kwu_key_model.sv ====
// key switch and release pin model at the far side of the wakeup block
`timescale 1ns/100ps
module kwu_key_model (
    input wire logic [3:0] pressKeys,
    input wire logic relLevel,
    output logic [3:0] keyWakePin,
    output logic releasePin
);
    // a pressed switch pulls its pin to ground; idle keys rest on pull-ups
    // pins carry digital levels only, never an analog conversion input
    assign keyWakePin = ~pressKeys;
    // release pin stays low unless the bench asks, so key wake can act
    assign releasePin = relLevel;
endmodule

// ==== dv/kwu_standby_release_tb.sv ====
// self-checking bench of the key-on wakeup standby release block
`timescale 1ns/100ps
`include "kwu_params.svh"
module kwu_standby_release_tb;
    import kwu_pkg::*;
    localparam int WARM = 6;
    logic core_clk, rst, psel, penable, pwrite, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, inStandby, inWarmup, relLevel, releasePin;
    logic [3:0] keyWakePin, pressKeys;
    int bad_count = 0;
    int compares = 0;
    int cycles = 0;
    kwu_standby_release #(.WARMUP_CYCLES(WARM)) kwu_standby_release_i (
        .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .keyWakePin(keyWakePin), .releasePin(releasePin), .inStandby(inStandby), .inWarmup(inWarmup)
    );
    kwu_key_model kwu_key_model_i (
        .pressKeys(pressKeys), .relLevel(relLevel), .keyWakePin(keyWakePin), .releasePin(releasePin)
    );
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // a hung handshake ends up here rather than spinning forever
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count = bad_count + 1;
            wrap_up();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // skip set: standby must never be seen before warm-up starts
    task automatic expect_warm(input logic skip);
        int k;
        logic seen;
        k = 0;
        seen = 1'b0;
        while (inWarmup !== 1'b1 && k < 40) begin
            @(posedge core_clk);
            seen = seen | (inStandby === 1'b1);
            k++;
        end
        check(32'(inWarmup), 32'h1);
        if (skip) check(32'(seen), 32'h0);
        k = 0;
        while (inWarmup === 1'b1 && k < 100) begin
            @(posedge core_clk);
            k++;
        end
        check(32'(k), 32'(WARM));
    endtask
    task automatic settle_standby(input logic exp);
        repeat (8) @(posedge core_clk);
        check(32'(inStandby), 32'(exp));
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata, pressKeys, relLevel} = '0;
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        apb(1'b0, `KWU_ADDR_ENABLE, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 12'h010, 32'h0);
        check(32'(err), 32'h1);
        apb(1'b0, `KWU_ADDR_STATUS, 32'h0);
        check(rd & 32'h3, 32'(KWU_RUN));
        settle_standby(1'b0);
        apb(1'b1, `KWU_ADDR_SYSCTL, 32'h000000c0);
        settle_standby(1'b1);
        apb(1'b0, `KWU_ADDR_STATUS, 32'h0);
        check(rd & 32'h3, 32'(KWU_STANDBY));
        apb(1'b0, `KWU_ADDR_SYSCTL, 32'h0);
        check(rd, 32'h00000040);
        check(32'(err), 32'h0);
        pressKeys <= 4'h4;
        settle_standby(1'b1);
        apb(1'b0, `KWU_ADDR_PINS, 32'h0);
        check(rd, 32'h0000000b);
        relLevel <= 1'b1;
        expect_warm(1'b0);
        relLevel <= 1'b0;
        apb(1'b1, `KWU_ADDR_ENABLE, 32'h00000040);
        apb(1'b0, `KWU_ADDR_ENABLE, 32'h0);
        check(rd, 32'h0);
        apb(1'b1, `KWU_ADDR_SYSCTL, 32'h000000c0);
        expect_warm(1'b1);
        pressKeys <= 4'h0;
        repeat (4) @(posedge core_clk);
        apb(1'b1, `KWU_ADDR_SYSCTL, 32'h000000c0);
        pressKeys <= 4'h1;
        settle_standby(1'b1);
        pressKeys <= 4'h5;
        expect_warm(1'b0);
        pressKeys <= 4'h0;
        apb(1'b1, `KWU_ADDR_ENABLE, 32'h0);
        apb(1'b1, `KWU_ADDR_SYSCTL, 32'h00000080);
        settle_standby(1'b1);
        relLevel <= 1'b1;
        expect_warm(1'b0);
        apb(1'b1, `KWU_ADDR_SYSCTL, 32'h00000080);
        expect_warm(1'b1);
        apb(1'b0, `KWU_ADDR_PINS, 32'h0);
        check(rd, 32'h0000001f);
        apb(1'b0, `KWU_ADDR_STATUS, 32'h0);
        check(rd, 32'h00000300);
        wrap_up();
    end
endmodule

// ==== hdl/kwu_standby_release.sv ====
// key-on wakeup standby entry and release controller with apb registers
// ----------------------------------------
// Summary of operation
// - standby entered only by control register write
// - enabled key pin low releases standby in level mode only
// - software reads current key pin levels
// - wake already present skips standby, warms up
// - release pin always acts, no enable
// - level mode levels; edge mode rising edge
// - write-only enables bits 7..4, reset zero
// ----------------------------------------
`timescale 1ns/100ps
`include "kwu_params.svh"
module kwu_standby_release
    import kwu_pkg::*;
#(
    parameter int WARMUP_CYCLES = `KWU_WARMUP_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] keyWakePin,
    input wire logic releasePin,
    output logic inStandby,
    output logic inWarmup
);
    initial begin
        if (WARMUP_CYCLES < 1 || WARMUP_CYCLES > 65535) begin
            $error("WARMUP_CYCLES out of range");
        end
    end

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    // keeps the release path on synchronised copies; a stopped clock would need an async latch
    logic [4:0] syncA, syncB, syncC;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            syncA <= `KWU_PIN_IDLE;
            syncB <= `KWU_PIN_IDLE;
            syncC <= `KWU_PIN_IDLE;
        end else begin
            syncA <= {releasePin, keyWakePin};
            syncB <= syncA;
            syncC <= syncB;
        end
    end
    // reset value is the pins' idle level (keys high, release low), so no false edge follows reset
    logic [3:0] keyLow;
    logic relHigh, relRise;
    assign keyLow = ~syncB[3:0];
    assign relHigh = syncB[4];
    assign relRise = syncB[4] & ~syncC[4];

    // ----------------------------------------
    // registers and state
    // ----------------------------------------
    logic [3:0] keyEnable, next_keyEnable;
    logic relMode, next_relMode;
    logic stopReq, next_stopReq;
    kwu_state_e state, next_state;
    logic [15:0] warmCnt, next_warmCnt;
    logic [7:0] releaseCount, next_releaseCount;
    logic [31:0] next_prdata;
    logic next_pready, next_pslverr;
    logic wrAccess, rdAccess, wakeLevel, wakeNow;

    assign wrAccess = psel & penable & pwrite & ~pready;
    assign rdAccess = psel & penable & ~pwrite & ~pready;
    // edge mode ignores the key pins entirely
    assign wakeLevel = relHigh | (|(keyLow & keyEnable));
    assign wakeNow = relMode ? wakeLevel : relRise;

    always_comb begin
        next_keyEnable = keyEnable;
        next_relMode = relMode;
        next_stopReq = 1'b0;
        next_state = state;
        next_warmCnt = warmCnt;
        next_releaseCount = releaseCount;
        next_prdata = 32'h0000_0000;
        next_pready = 1'b0;
        next_pslverr = 1'b0;
        if (psel & penable & ~pready) begin
            next_pready = 1'b1;
            if (paddr == `KWU_ADDR_ENABLE) begin
                if (pwrite) begin
                    next_keyEnable = pwdata[`KWU_EN_MSB:`KWU_EN_LSB];
                end
            end else if (paddr == `KWU_ADDR_SYSCTL) begin
                if (pwrite) begin
                    next_relMode = pwdata[`KWU_SYS_RELM_BIT];
                    next_stopReq = pwdata[`KWU_SYS_STOP_BIT];
                end else begin
                    next_prdata[`KWU_SYS_RELM_BIT] = relMode;
                end
            end else if (paddr == `KWU_ADDR_STATUS) begin
                if (!pwrite) begin
                    next_prdata = {16'h0000, releaseCount, 6'h00, state};
                end
            end else if (paddr == `KWU_ADDR_PINS) begin
                if (!pwrite) begin
                    next_prdata[4:0] = {relHigh, ~keyLow};
                end
            end else begin
                next_pslverr = 1'b1;
            end
        end
        case (state)
            KWU_RUN: begin
                if (stopReq) begin
                    // a wake already pending skips standby straight into warm-up
                    if (relMode ? wakeLevel : relHigh) begin
                        next_state = KWU_WARMUP;
                        next_warmCnt = 16'(WARMUP_CYCLES);
                    end else begin
                        next_state = KWU_STANDBY;
                    end
                end
            end
            KWU_STANDBY: begin
                if (wakeNow) begin
                    next_state = KWU_WARMUP;
                    next_warmCnt = 16'(WARMUP_CYCLES);
                    next_releaseCount = releaseCount + 8'h01;
                end
            end
            KWU_WARMUP: begin
                if (warmCnt <= 16'h0001) begin
                    next_state = KWU_RUN;
                    next_warmCnt = 16'h0000;
                end else begin
                    next_warmCnt = warmCnt - 16'h0001;
                end
            end
            default: begin
                next_state = KWU_RUN;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            keyEnable <= `KWU_EN_RESET;
            relMode <= 1'b0;
            stopReq <= 1'b0;
            state <= KWU_RUN;
            warmCnt <= 16'h0000;
            releaseCount <= 8'h00;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            inStandby <= 1'b0;
            inWarmup <= 1'b0;
        end else begin
            keyEnable <= next_keyEnable;
            relMode <= next_relMode;
            stopReq <= next_stopReq;
            state <= next_state;
            warmCnt <= next_warmCnt;
            releaseCount <= next_releaseCount;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            inStandby <= (next_state == KWU_STANDBY);
            inWarmup <= (next_state == KWU_WARMUP);
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    property p_entry_needs_write;
        @(posedge core_clk) disable iff (rst)
        ($rose(inStandby) || ($rose(inWarmup) && $past(state) == KWU_RUN)) |-> $past(stopReq);
    endproperty
    a_entry_needs_write: assert property (p_entry_needs_write) else $error("standby without request");

    property p_key_release;
        @(posedge core_clk) disable iff (rst)
        (state == KWU_STANDBY && relMode && |(keyLow & keyEnable)) |=> inWarmup;
    endproperty
    a_key_release: assert property (p_key_release) else $error("enabled key low did not release");

    property p_pin_read;
        @(posedge core_clk) disable iff (rst)
        (rdAccess && paddr == `KWU_ADDR_PINS) |=> prdata[3:0] == ~$past(keyLow);
    endproperty
    a_pin_read: assert property (p_pin_read) else $error("pin levels misread");

    property p_immediate;
        @(posedge core_clk) disable iff (rst)
        (state == KWU_RUN && stopReq && relHigh) |=> (state == KWU_WARMUP && !inStandby);
    endproperty
    a_immediate: assert property (p_immediate) else $error("standby entered with wake pending");

    property p_release_pin;
        @(posedge core_clk) disable iff (rst)
        (state == KWU_STANDBY && relMode && relHigh) |=> state == KWU_WARMUP;
    endproperty
    a_release_pin: assert property (p_release_pin) else $error("release pin ignored");

    property p_edge_ignores_keys;
        @(posedge core_clk) disable iff (rst)
        (state == KWU_STANDBY && !relMode && !relRise) |=> state == KWU_STANDBY;
    endproperty
    a_edge_ignores_keys: assert property (p_edge_ignores_keys) else $error("edge mode left without rise");

    property p_enable_write;
        @(posedge core_clk) disable iff (rst)
        (wrAccess && paddr == `KWU_ADDR_ENABLE) |=> keyEnable == $past(pwdata[7:4]);
    endproperty
    a_enable_write: assert property (p_enable_write) else $error("enable bits not stored");

    property p_sync_delay;
        @(posedge core_clk) disable iff (rst)
        (!$past(rst) && !$past(rst, 2)) |-> (keyLow == ~$past(keyWakePin, 2) && relHigh == $past(releasePin, 2));
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("key pin not synchronised");
endmodule

// ==== inc/kwu_params.svh ====
// constants of the key-on wakeup standby release block
`ifndef KWU_PARAMS_SVH
`define KWU_PARAMS_SVH
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define KWU_ADDR_ENABLE 12'h000
`define KWU_ADDR_SYSCTL 12'h004
`define KWU_ADDR_STATUS 12'h008
`define KWU_ADDR_PINS 12'h00c
// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define KWU_EN_LSB 4
`define KWU_EN_MSB 7
`define KWU_EN_RESET 4'h0
`define KWU_SYS_STOP_BIT 7
`define KWU_SYS_RELM_BIT 6
`define KWU_SYS_RESET 8'h00
`define KWU_PIN_IDLE 5'h0f
`define KWU_WARMUP_CYCLES 16
`endif

// ==== inc/kwu_pkg.sv ====
// types of the key-on wakeup standby release block
package kwu_pkg;
    typedef enum logic [1:0] {
        KWU_RUN = 2'b00,
        KWU_STANDBY = 2'b01,
        KWU_WARMUP = 2'b10
    } kwu_state_e;
endpackage
